// ---- include/pcm_defines.svh ----
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// Register byte offsets
`define VP_CTRL_OFS   8'h00
`define VP_CHAN_OFS   8'h04
`define VP_DIV_OFS    8'h08
`define VP_STAT_OFS   8'h0C

// Reset values: port off, 13-bit sample left justified, MSB first
`define VP_CTRL_RST   32'h0003_0000
`define VP_CHAN_RST   32'h0000_0000
`define VP_DIV_RST    8'h05

// Channel map field layout, one byte per channel
`define VP_CH_STRIDE  8
`define VP_CH_EN_BIT  4

// Status bit positions
`define VP_ST_CFGERR  0
`define VP_ST_OVR     1
`define VP_ST_UND     2

// Fill pattern codes for the three spare bits
`define VP_FILL_ZERO  2'h0
`define VP_FILL_ONES  2'h1
`define VP_FILL_SIGN  2'h2

// Timing counts
`define VP_MIN_DIV    8'h02
`define VP_MAX_RSEL   3'h4
`define VP_LONG_BITS  8'h03
`define VP_LAST_BIT   4'hF

`endif

// ---- include/pcm_pkg.sv ----
package pcm_pkg;

    // Control register image
    typedef struct packed {
        logic [6:0] pad2;
        logic [4:0] slotCount;
        logic [1:0] pad1;
        logic [1:0] pos;
        logic [2:0] fillVal;
        logic [1:0] fillMode;
        logic       lsbFirst;
        logic [1:0] wideband_voice_mode;
        logic       pad0;
        logic [2:0] rateSel;
        logic       rate16k;
        logic       longSync;
        logic       master;
        logic       en;
    } cfg_t;

    // One received word with its channel
    typedef struct packed {
        logic [1:0]  chan;
        logic [15:0] data;
    } sample_t;

    typedef enum logic [1:0] {IDLE, HUNT, RUN} frame_state_t;

endpackage : pcm_pkg

// ---- core/pcm_sync2.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser for pins from outside the clock domain
module pcm_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    if (W < 1) begin : g_bad_w
        $error("pcm_sync2: W must be at least 1");
    end

    // Only the second stage is visible to logic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : pcm_sync2

// ---- core/pcm_buf2.sv ----
`timescale 1ns/1ps
// Two-entry buffer; head register feeds the output directly
module pcm_buf2 #(
    parameter int W     = 18,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);
    logic [W-1:0] tail;
    logic         tailValid;

    if (DEPTH != 2) begin : g_bad_depth
        $error("pcm_buf2: only DEPTH 2 is supported");
    end

    wire push = inValid & inReady;
    wire pop  = outValid & outReady;

    // Head refills from tail first so order is kept
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            outValid  <= 1'b0;
            tailValid <= 1'b0;
            outData   <= '0;
            tail      <= '0;
            inReady   <= 1'b1;
        end else if (!outValid || pop) begin
            if (tailValid) begin
                outData   <= tail;
                tail      <= inData;
                tailValid <= push;
                inReady   <= ~push;
            end else begin
                outData   <= inData;
                outValid  <= push;
            end
        end else if (push) begin
            tail      <= inData;
            tailValid <= 1'b1;
            inReady   <= 1'b0;
        end
    end
endmodule : pcm_buf2

// ---- core/voice_pcm_serial_port.sv ----
// How it works
// - Master mode drives bit clock and frame sync, slave mode takes them in.
// - Up to three channels run at once, each mapped to any slot.
// - At 8 kHz the slot count is 1, 2, 4, 8 or 16 for rates 128 to 2048.
// - A channel transmits and receives in the same slot number.
// - Data output is high impedance in every slot no channel owns.
// - Leaving a driven slot, output releases after the last bit's fall.
// - Transparent wideband mode passes 16-bit words through unchanged.
// - On-chip codec mode exchanges linear 16-bit samples unchanged.
// - Short and long sync both work in master and slave mode.
// - Short sync is a one-bit-wide high pulse timed from a rising edge.
// - Slave sees short sync high at a fall; bit 0 starts at next rise.
// - Long sync is three bits high, starting with the first bit.
// - A 16-bit word holds 13 sample bits at a set position and order.
// - Spare bits are dropped on receive and filled on transmit.
// - Reset format is 13-bit two's complement, left justified, MSB first.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "pcm_defines.svh"
module voice_pcm_serial_port import pcm_pkg::*; #(
    parameter int CHANNELS = 3
) (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          bclkIn,
    output logic                               bclkOut,
    output logic                               bclkOe,
    input  wire logic                          syncIn,
    output logic                               syncOut,
    output logic                               syncOe,
    input  wire logic                          dataIn,
    output logic                               dataOut,
    output logic                               dataOe,
    input  wire logic [CHANNELS-1:0]           txValid,
    input  wire logic [CHANNELS-1:0][15:0]     txData,
    output logic      [CHANNELS-1:0]           txReady,
    output logic                               rxValid,
    input  wire logic                          rxReady,
    output sample_t                            rxSample
);
    if (CHANNELS < 1 || CHANNELS > 3) begin : g_bad_ch
        $error("voice_pcm_serial_port: CHANNELS must be 1 to 3");
    end

    cfg_t                 cfg;
    logic [31:0]          chanMap;
    logic [7:0]           divHalf;
    logic                 overrun, underrun;
    frame_state_t         state;
    logic [7:0]           pos, divCnt;
    logic                 startPend, startVal, syncPrev, bclkPrev;
    logic [15:0]          txShift, rxShift;
    logic [1:0]           txCh;
    logic [CHANNELS-1:0][15:0] txHold;
    logic                 rxPushV;
    sample_t              rxPushD;
    logic [2:0]           pinS;
    logic                 bufReady;
    logic                 cfgErr;

    // APB decode; one wait state so read data leaves a flop
    wire selCtrl  = paddr == `VP_CTRL_OFS;
    wire selChan  = paddr == `VP_CHAN_OFS;
    wire selDiv   = paddr == `VP_DIV_OFS;
    wire selStat  = paddr == `VP_STAT_OFS;
    wire mapped   = selCtrl | selChan | selDiv | selStat;
    wire access   = psel & penable & ~pready;
    wire wrEn     = psel & penable & pready & pwrite & mapped;
    wire [31:0] statWord = {16'h0, pos, 5'h0, underrun, overrun, cfgErr};
    wire [31:0] rdMux = selCtrl ? cfg :
                        selChan ? chanMap :
                        selDiv  ? {24'h0, divHalf} :
                        selStat ? statWord : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            if (access) begin
                prdata  <= pwrite ? 32'h0 : rdMux;
                pslverr <= ~mapped;
            end
        end
    end

    // Slot count and frame length
    wire [4:0] tblSlots = 5'h01 << cfg.rateSel;
    wire [4:0] slots    = cfg.rate16k ? cfg.slotCount : tblSlots;
    assign     cfgErr   = (cfg.rateSel > `VP_MAX_RSEL) |
                          (cfg.rate16k & ((cfg.slotCount == 5'h00) |
                          (cfg.slotCount > (tblSlots >> 1)))) |
                          (cfg.master & (divHalf < `VP_MIN_DIV));
    wire [7:0] lastPos  = {4'(slots - 5'h01), `VP_LAST_BIT};
    wire       runOk    = cfg.en & ~cfgErr;

    // Lowest numbered channel wins if two share a slot
    function automatic logic [2:0] owner(input logic [3:0] s);
        logic [2:0] r;
        r = 3'h0;
        for (int c = CHANNELS - 1; c >= 0; c--) begin
            if (chanMap[c*`VP_CH_STRIDE + `VP_CH_EN_BIT] &&
                chanMap[c*`VP_CH_STRIDE +: 4] == s &&
                {1'b0, s} < slots)
                r = {1'b1, 2'(c)};
        end
        return r;
    endfunction : owner

    // Sample to wire word: position and fill except in wideband mode, then order
    function automatic logic [15:0] fmtTx(input logic [15:0] d);
        logic [31:0] pat;
        logic [15:0] fill, w;
        pat  = {29'h0, cfg.fillVal} << (5'h0D + {3'h0, cfg.pos});
        fill = pat[15:0] | pat[31:16];
        if (cfg.fillMode == `VP_FILL_ZERO)
            fill = 16'h0000;
        else if (cfg.fillMode == `VP_FILL_ONES)
            fill = 16'hFFFF;
        else if (cfg.fillMode == `VP_FILL_SIGN)
            fill = {16{d[12]}};
        w = ({3'h0, d[12:0]} << cfg.pos) |
            (fill & ~(16'h1FFF << cfg.pos));
        if (cfg.wideband_voice_mode != 2'h0)
            w = d;
        if (cfg.lsbFirst)
            w = {<<{w}};
        return w;
    endfunction : fmtTx

    // Wire word to sample: sign-extended, spare bits dropped, except in wideband mode
    function automatic logic [15:0] parseRx(input logic [15:0] raw);
        logic [15:0] w;
        logic [12:0] s;
        w = raw;
        if (cfg.lsbFirst)
            w = {<<{raw}};
        s = 13'(w >> cfg.pos);
        return (cfg.wideband_voice_mode != 2'h0) ? w :
               {{3{s[12]}}, s};
    endfunction : parseRx

    // Edge events: own divider in master, sampled pin in slave
    wire masterRun = cfg.master & (state != IDLE);
    wire tick      = divCnt == 8'h00;
    wire rise      = cfg.master ? (masterRun & tick & ~bclkOut) :
                     (pinS[0] & ~bclkPrev);
    wire fall      = cfg.master ? (masterRun & tick & bclkOut) :
                     (~pinS[0] & bclkPrev);
    wire running   = state == RUN;
    wire [7:0] next_pos = startPend ? {7'h0, startVal} :
                          (pos == lastPos) ? 8'h00 : pos + 8'h01;
    wire [2:0] newOwn   = owner(next_pos[7:4]);
    wire [3:0] nextSlot = (pos == lastPos) ? 4'h0 : pos[7:4] + 4'h1;
    wire [2:0] curOwn   = owner(pos[7:4]);
    wire [2:0] folOwn   = owner(nextSlot);
    wire       slotLoad = rise & running & newOwn[2] &
                          (next_pos[3:0] == 4'h0);
    wire [15:0] txWord  = fmtTx(txHold[newOwn[1:0]]);

    pcm_sync2 #(.W(3)) u_pins (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({dataIn, syncIn, bclkIn}),
        .q       (pinS)
    );

    // Register writes; overrun and underrun clear on 1, a new event wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg      <= `VP_CTRL_RST;
            chanMap  <= `VP_CHAN_RST;
            divHalf  <= `VP_DIV_RST;
            overrun  <= 1'b0;
            underrun <= 1'b0;
        end else begin
            if (wrEn && selCtrl) cfg     <= pwdata;
            if (wrEn && selChan) chanMap <= pwdata;
            if (wrEn && selDiv)  divHalf <= pwdata[7:0];
            if (wrEn && selStat && pwdata[`VP_ST_OVR]) overrun  <= 1'b0;
            if (wrEn && selStat && pwdata[`VP_ST_UND]) underrun <= 1'b0;
            if (rxPushV && !bufReady) overrun <= 1'b1;
            if (slotLoad && txReady[newOwn[1:0]]) underrun <= 1'b1;
        end
    end

    // Frame state
    always_ff @(posedge clk_sys) begin
        if (reset || !runOk) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE:    state <= cfg.master ? RUN : HUNT;
                HUNT:    if (rise && startPend) state <= RUN;
                RUN:     state <= RUN;
                default: state <= IDLE;
            endcase
        end
    end

    // Master bit clock divider
    always_ff @(posedge clk_sys) begin
        if (reset || !masterRun) begin
            divCnt  <= 8'h00;
            bclkOut <= 1'b0;
        end else if (tick) begin
            divCnt  <= divHalf;
            bclkOut <= ~bclkOut;
        end else begin
            divCnt  <= divCnt - 8'h01;
        end
    end

    // Pin directions and master frame sync
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bclkOe  <= 1'b1;
            syncOe  <= 1'b1;
            syncOut <= 1'b0;
        end else begin
            bclkOe  <= ~(cfg.master & runOk);
            syncOe  <= ~(cfg.master & runOk);
            if (!masterRun)
                syncOut <= 1'b0;
            else if (rise)
                syncOut <= cfg.longSync ?
                           (next_pos < `VP_LONG_BITS) :
                           (next_pos == lastPos);
        end
    end

    // Bit position; slave realigns on each sync
    always_ff @(posedge clk_sys) begin
        if (reset || state == IDLE) begin
            pos       <= lastPos;
            startPend <= 1'b0;
            startVal  <= 1'b0;
            syncPrev  <= 1'b0;
            bclkPrev  <= 1'b0;
        end else begin
            bclkPrev <= pinS[0];
            if (rise) begin
                pos       <= next_pos;
                startPend <= 1'b0;
            end
            if (fall && !cfg.master) begin
                syncPrev <= pinS[1];
                if (pinS[1] && (!cfg.longSync || !syncPrev)) begin
                    startPend <= 1'b1;
                    startVal  <= cfg.longSync;
                end
            end
        end
    end

    // Transmit shifter: load at slot start, shift on rises
    always_ff @(posedge clk_sys) begin
        if (reset || !running) begin
            dataOe  <= 1'b1;
            dataOut <= 1'b0;
            txShift <= 16'h0000;
            txCh    <= 2'h0;
        end else begin
            if (slotLoad) begin
                dataOut <= txWord[15];
                txShift <= {txWord[14:0], 1'b0};
                dataOe  <= 1'b0;
                txCh    <= newOwn[1:0];
            end else if (rise && !dataOe) begin
                dataOut <= txShift[15];
                txShift <= {txShift[14:0], 1'b0};
            end
            // Stay driven into a following owned slot
            if (fall && pos[3:0] == `VP_LAST_BIT && !folOwn[2])
                dataOe <= 1'b1;
        end
    end

    // Transmit holding words; empty holding repeats last word
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txReady <= '1;
            txHold  <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (slotLoad && newOwn[1:0] == 2'(c))
                    txReady[c] <= 1'b1;
                if (txValid[c] && txReady[c]) begin
                    txHold[c]  <= txData[c];
                    txReady[c] <= 1'b0;
                end
            end
        end
    end

    // Receive shifter sampled on falls
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxShift <= 16'h0000;
            rxPushV <= 1'b0;
            rxPushD <= '0;
        end else begin
            rxPushV <= 1'b0;
            if (fall && running) begin
                rxShift <= {rxShift[14:0], pinS[2]};
                if (pos[3:0] == `VP_LAST_BIT && curOwn[2]) begin
                    rxPushV <= 1'b1;
                    rxPushD <= '{chan: curOwn[1:0],
                                 data: parseRx({rxShift[14:0], pinS[2]})};
                end
            end
        end
    end

    // Receive buffer absorbs a short stall of the reader
    pcm_buf2 #(.W($bits(sample_t)), .DEPTH(2)) u_rxbuf (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .inValid  (rxPushV),
        .inReady  (bufReady),
        .inData   (rxPushD),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (rxSample)
    );

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence lastBitFall;
        fall && running && pos[3:0] == `VP_LAST_BIT;
    endsequence

    a_master_pins: assert property (state == RUN && cfg.master |->
        !bclkOe && !syncOe) else $error("master not driving clock");
    a_slot_table: assert property (!cfg.rate16k &&
        cfg.rateSel == 3'h4 |-> lastPos == 8'hFF && slots == 5'h10)
        else $error("slot count wrong for top rate");
    a_hiz_unused: assert property (running && $past(running) &&
        !dataOe |-> curOwn[2]) else $error("driving an unused slot");
    a_release_edge: assert property (running && $past(running) &&
        $rose(dataOe) |-> $past(fall) && $past(pos[3:0]) == 4'hF)
        else $error("release not after last bit fall");
    a_same_slot: assert property (lastBitFall and !dataOe
        |=> rxPushV && rxPushD.chan == $past(txCh))
        else $error("tx and rx slots differ");
    a_short_sync: assert property (masterRun && !cfg.longSync &&
        syncOut |-> pos == lastPos) else $error("short sync misplaced");
    a_long_sync: assert property (masterRun && cfg.longSync &&
        rise ##1 syncOut |-> pos < 8'h03) else $error("long sync width");
    a_slave_start: assert property (!cfg.master && state == HUNT &&
        rise && startPend && !startVal |=> pos == 8'h00)
        else $error("slave frame start wrong");
    a_wide_pass: assert property (cfg.wideband_voice_mode != 2'h0 &&
        !cfg.lsbFirst |-> txWord == txHold[newOwn[1:0]])
        else $error("wideband word altered");
    a_fill_ones: assert property (cfg.wideband_voice_mode == 2'h0 &&
        cfg.fillMode == `VP_FILL_ONES && cfg.pos == 2'h3 &&
        !cfg.lsbFirst |-> txWord[2:0] == 3'h7)
        else $error("fill pattern wrong");
    a_reset_fmt: assert property ($past(reset) |-> cfg.pos == 2'h3 &&
        !cfg.lsbFirst && cfg.fillMode == 2'h0)
        else $error("reset format wrong");
    a_cfg_check: assert property (cfg.rate16k &&
        cfg.slotCount > (tblSlots >> 1) |=> state == IDLE)
        else $error("bad slot count accepted");
    a_three_ch: assert property (rxPushV |->
        32'(rxPushD.chan) < CHANNELS) else $error("channel out of range");
endmodule : voice_pcm_serial_port

// ---- verif/pcm_codec_master.sv ----
`timescale 1ns/1ps
// Far-side bus master: makes bit clock and sync, two slots per frame
module pcm_codec_master (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic        longSync,
    input  wire logic [1:0]  frames,
    input  wire logic [31:0] sendBits,
    input  wire logic        dataOut,
    input  wire logic        dataOe,
    output logic             bclk,
    output logic             sync,
    output logic             dataIn,
    output logic             busy,
    output logic [31:0]      gotBits,
    output logic [31:0]      gotOe
);
    // One bit is 8 clk_sys cycles, 320 ns; edges are sampled by the port
    task automatic bit_out(input logic s, input logic d, input int i);
        bclk <= 1'b1;
        sync <= s;
        dataIn <= d;
        repeat (4) @(posedge clk_sys);
        bclk <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // Sample late, yet before the port can release after the fall
        if (i >= 0) begin
            gotBits[31-i] <= dataOut;
            gotOe[31-i] <= dataOe;
        end
        repeat (2) @(posedge clk_sys);
    endtask : bit_out

    // Clock stands still between runs; idle data keeps changing
    initial begin
        bclk <= 1'b0;
        sync <= 1'b0;
        dataIn <= 1'b0;
        busy <= 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go) begin
                busy <= 1'b1;
                if (!longSync) bit_out(1'b1, 1'b0, -1);
                for (int f = 0; f < frames; f++)
                    for (int i = 0; i < 32; i++)
                        bit_out(longSync ? i < 3 : i == 31,
                                sendBits[31-i], i);
                sync <= 1'b0;
                busy <= 1'b0;
            end else dataIn <= ~dataIn;
        end
    end
endmodule : pcm_codec_master

// ---- verif/voice_pcm_serial_port_tb.sv ----
`timescale 1ns/1ps
`include "pcm_defines.svh"
module voice_pcm_serial_port_tb import pcm_pkg::*;;
    logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, rxReady = 1'b1, go = 1'b0, lsync = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, sendBits = 32'h0, gotBits, gotOe;
    logic [31:0] rd;
    logic err, pready, pslverr, bclkOut, bclkOe, syncOut, syncOe;
    logic dataOut, dataOe, rxValid, busy, pBclk, pSync, dataIn;
    logic bclkPin, syncPin, sPrev = 1'b0;
    logic [1:0] frames = 2'h2;
    logic [2:0] txValid = 3'h0, txReady;
    logic [2:0][15:0] txData = '0;
    sample_t rxSample, rxLast;
    int n_mismatch = 0, samples_checked = 0, rxCount = 0;
    int cyc = 0, frameCyc = 0, hi = 0, syncHi = 0;
    localparam logic [15:0] W = 16'h9C6F;
    localparam logic [12:0] S = 13'h1A5B;
    localparam logic [12:0] P = 13'h0A5B;
    localparam logic [31:0] C = 32'h0003_0011;

    // Pin level from the port's enables; the codec drives whenever the port releases
    assign bclkPin = bclkOe ? pBclk : bclkOut;
    assign syncPin = syncOe ? pSync : syncOut;

    voice_pcm_serial_port u_dut (.clk_sys(clk_sys), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bclkIn(bclkPin), .bclkOut(bclkOut),
        .bclkOe(bclkOe), .syncIn(syncPin), .syncOut(syncOut),
        .syncOe(syncOe), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .txValid(txValid), .txData(txData),
        .txReady(txReady), .rxValid(rxValid), .rxReady(rxReady),
        .rxSample(rxSample));
    pcm_codec_master u_codec (.clk_sys(clk_sys), .go(go),
        .longSync(lsync), .frames(frames), .sendBits(sendBits),
        .dataOut(dataOut), .dataOe(dataOe), .bclk(pBclk), .sync(pSync),
        .dataIn(dataIn), .busy(busy), .gotBits(gotBits), .gotOe(gotOe));

    initial forever #20 clk_sys = ~clk_sys;

    // Receive sink, master frame length and sync width
    always @(posedge clk_sys) begin
        sPrev <= syncOut;
        cyc <= (syncOut && !sPrev) ? 1 : cyc + 1;
        if (syncOut && !sPrev) frameCyc <= cyc;
        hi <= syncOut ? hi + 1 : 0;
        if (!syncOut && sPrev) syncHi <= hi;
        if (rxValid === 1'b1 && rxReady) begin
            rxLast <= rxSample;
            rxCount <= rxCount + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; holds the request until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) n_mismatch++;
    endtask : apb

    function automatic logic [15:0] sx(input logic [15:0] w);
        return {{3{w[15]}}, w[15:3]};
    endfunction : sx
    function automatic logic [15:0] rev(input logic [15:0] w);
        logic [15:0] r;
        r = {<<{w}};
        return r;
    endfunction : rev

    // Restart port, load one word, let the codec run its frames
    task automatic start(input logic [31:0] ctrl, input logic [15:0] tw);
        int n;
        apb(1'b1, `VP_CTRL_OFS, ctrl & 32'hFFFF_FFFE);
        apb(1'b1, `VP_CTRL_OFS, ctrl);
        lsync <= ctrl[2];
        txValid[0] <= 1'b1;
        txData[0] <= tw;
        n = 0;
        do @(posedge clk_sys); while (txReady[0] !== 1'b0 && ++n < 50);
        if (n >= 50) n_mismatch++;
        txValid[0] <= 1'b0;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        do @(posedge clk_sys); while (busy !== 1'b0 && ++n < 3000);
        if (n >= 3000) n_mismatch++;
        repeat (10) @(posedge clk_sys);
    endtask : start

    task automatic run_case(input logic [31:0] ctrl, input logic [15:0] tw,
                            input logic [15:0] eTx, input logic [15:0] eRx);
        start(ctrl, tw);
        check(gotBits[15:0], eTx);
        check(gotOe, 32'hFFFF_0000);
        check({14'h0, rxLast}, {16'h0, 2'h0, eRx});
        $display("case ctrl %h done", ctrl);
    endtask : run_case

    task automatic test_regs();
        apb(1'b0, `VP_CTRL_OFS, 32'h0);
        check(rd, 32'h0003_0000);
        apb(1'b0, `VP_DIV_OFS, 32'h0);
        check(rd, 32'h0000_0005);
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, `VP_CTRL_OFS, 32'h0013_0009);
        apb(1'b0, `VP_STAT_OFS, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        apb(1'b1, `VP_CTRL_OFS, 32'h0003_0051);
        apb(1'b0, `VP_STAT_OFS, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        apb(1'b1, `VP_CHAN_OFS, 32'h0000_0011);
        apb(1'b0, `VP_CHAN_OFS, 32'h0);
        check(rd, 32'h0000_0011);
        $display("registers done");
    endtask : test_regs

    task automatic test_master();
        apb(1'b1, `VP_CTRL_OFS, 32'h0003_0013);
        repeat (1500) @(posedge clk_sys);
        check({30'h0, bclkOe, syncOe}, 32'h0);
        check(frameCyc, 32 * 12);
        check(syncHi, 12);
        apb(1'b1, `VP_CTRL_OFS, 32'h0003_0017);
        repeat (1000) @(posedge clk_sys);
        check(syncHi, 36);
        check(frameCyc, 32 * 12);
        apb(1'b1, `VP_CTRL_OFS, C & 32'hFFFF_FFFE);
        $display("master done");
    endtask : test_master

    // Stall the reader over three words: two kept, one dropped
    task automatic test_buffer();
        int n;
        rxReady <= 1'b0;
        frames <= 2'h3;
        start(C, {3'h0, S});
        apb(1'b0, `VP_STAT_OFS, 32'h0);
        check({30'h0, rd[1], rxValid}, 32'h3);
        n = rxCount;
        rxReady <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check(rxCount - n, 2);
        apb(1'b1, `VP_STAT_OFS, 32'h0000_0002);
        apb(1'b0, `VP_STAT_OFS, 32'h0);
        check({31'h0, rd[1]}, 32'h0);
        $display("buffer done");
    endtask : test_buffer

    task automatic close_out();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    initial begin
        #2_000_000;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs();
        test_master();
        sendBits <= {~W, W};
        run_case(C, {3'h0, S}, {S, 3'h0}, sx(W));
        run_case(C | 32'h800, {3'h0, S}, {S, 3'h7}, sx(W));
        run_case(C | 32'h1000, {3'h0, P}, {P, 3'h0}, sx(W));
        run_case(C | 32'hB800, {3'h0, S}, {S, 3'h5}, sx(W));
        run_case(C | 32'h4, {3'h0, S}, {S, 3'h0}, sx(W));
        run_case(C | 32'h400, {3'h0, S}, rev({S, 3'h0}), sx(rev(W)));
        run_case(C | 32'h100, 16'hC3A5, 16'hC3A5, W);
        run_case(C | 32'h200, 16'h5A3C, 16'h5A3C, W);
        test_buffer();
        close_out();
    end
endmodule : voice_pcm_serial_port_tb
